// *** serial_flash_command_port_tb.sv ***
// testbench: command frames into the flash command port
`timescale 1ns/1ps
module serial_flash_command_port_tb;
	localparam int OPC = 1200;
	localparam logic [7:0] SID = 8'h3E; // arbitrary value
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sck, sdi, cs_n, dout, oe_n, req_valid, oe_seen;
	logic [7:0] rdata, status;
	logic [23:0] raddr;
	sfcp_pkg::sfcp_page_type page, last_pg;
	sfcp_pkg::sfcp_req_type req, last_req;
	int n_mismatch = 0;
	int check_count = 0;
	int req_seen = 0;
	int pg_seen = 0;
	logic [7:0] rdq[$];
	logic rv1, rv16, oe16;
	sfcp_pkg::sfcp_req_type req1, req16;
	logic [4:0] sec1, sec16;
	int oe16_cnt = 0;
	sfcp_core #(.OP_CYCLES(OPC), .SILICON_ID(SID)) dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
		.serial_clock_in_i(sck), .serial_cmd_in_i(sdi), .chip_select_n_i(cs_n), .mem_rdata_i(rdata),
		.data_out_o(dout), .data_oe_n_o(oe_n), .mem_raddr_o(raddr), .page_o(page), .req_o(req),
		.req_valid_o(req_valid), .status_o(status));
	// smaller and larger variants listen to the same frames, so their decode can be compared
	sfcp_core #(.VARIANT(sfcp_pkg::VAR_1MBIT), .OP_CYCLES(OPC)) dut1_u (.mclk_i(mclk_i), .rst_i(rst_i),
		.serial_clock_in_i(sck), .serial_cmd_in_i(sdi), .chip_select_n_i(cs_n), .mem_rdata_i(rdata),
		.data_out_o(), .data_oe_n_o(), .mem_raddr_o(), .page_o(), .req_o(req1),
		.req_valid_o(rv1), .status_o());
	sfcp_core #(.VARIANT(sfcp_pkg::VAR_16MBIT), .OP_CYCLES(OPC)) dut16_u (.mclk_i(mclk_i), .rst_i(rst_i),
		.serial_clock_in_i(sck), .serial_cmd_in_i(sdi), .chip_select_n_i(cs_n), .mem_rdata_i(rdata),
		.data_out_o(), .data_oe_n_o(oe16), .mem_raddr_o(), .page_o(), .req_o(req16),
		.req_valid_o(rv16), .status_o());
	sfcp_host host_u (.mclk_i(mclk_i), .data_i(dout), .oe_n_i(oe_n), .raddr_i(raddr), .sck_o(sck),
		.sdi_o(sdi), .cs_n_o(cs_n), .rdata_o(rdata), .oe_seen_o(oe_seen));
	initial begin
		forever #2.5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		if (req_valid) begin
			req_seen <= req_seen + 1;
			last_req <= req;
		end
		if (page.wr) begin
			pg_seen <= pg_seen + 1;
			last_pg <= page;
		end
		if (rv1) begin
			sec1 <= req1.sector;
		end
		if (rv16) begin
			sec16 <= req16.sector;
		end
		if (!oe16) begin
			oe16_cnt <= oe16_cnt + 1;
		end
	end
	// ====
	// shared tasks
	function automatic logic [7:0] img(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
	endfunction
	task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic send(input logic [7:0] q[$], input int nrd, input int nbits);
		logic [7:0] r;
		rdq.delete();
		host_u.open_frame();
		foreach (q[i]) host_u.shift(q[i], 8, r);
		repeat (nrd) begin
			host_u.shift(8'h00, 8, r);
			rdq.push_back(r);
		end
		if (nbits > 0) host_u.shift(8'hFF, nbits, r);
		host_u.close_frame();
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while (status[0] !== 1'b0 && k < 1500) begin
			@(negedge mclk_i);
			k++;
		end
		check(k < 1500, 1, "busy end");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ====
	// scenarios
	task automatic t_reset();
		check(status, 8'h00, "status reset");
		check(oe_n, 1'b1, "oe reset");
	endtask
	task automatic t_wel();
		send('{sfcp_pkg::OP_WREN}, 0, 0);
		check(status, 8'h02, "wel set");
		send('{sfcp_pkg::OP_RDSR}, 2, 0);
		check({rdq[0], rdq[1]}, 16'h0202, "status read");
		send('{sfcp_pkg::OP_WRDI}, 0, 0);
		check(status, 8'h00, "wel clear");
	endtask
	task automatic t_read();
		send('{sfcp_pkg::OP_READ, 8'h07, 8'hFF, 8'hFE}, 3, 0);
		check(rdq[0], img(24'h07FFFE), "read first");
		check(rdq[1], img(24'h07FFFF), "read top");
		check(rdq[2], img(24'h000000), "read wrap");
	endtask
	task automatic t_refuse();
		int n0;
		n0 = req_seen;
		send('{sfcp_pkg::OP_WREN}, 0, 0);
		send('{sfcp_pkg::OP_PROG, 8'h00, 8'h01, 8'h00, 8'h11}, 0, 4);
		check(req_seen, n0, "partial byte");
		send('{sfcp_pkg::OP_WRDI}, 0, 0);
		send('{sfcp_pkg::OP_SECT, 8'h01, 8'h00, 8'h00}, 0, 0);
		check(req_seen, n0, "no latch");
	endtask
	task automatic t_prog();
		int n0, p0;
		n0 = req_seen;
		p0 = pg_seen;
		send('{sfcp_pkg::OP_WREN}, 0, 0);
		send('{sfcp_pkg::OP_PROG, 8'h01, 8'h23, 8'hFE, 8'hA1, 8'hB2}, 0, 0);
		check(req_seen - n0, 1, "prog commit");
		check({last_req.op, last_req.addr}, {sfcp_pkg::SFCP_OP_PROG, 24'h0123FE}, "prog req");
		check(pg_seen - p0, 2, "page writes");
		check({last_pg.idx, last_pg.data}, 16'hFFB2, "page last");
		send('{sfcp_pkg::OP_RDSR}, 1, 0);
		check(rdq[0], 8'h03, "busy status");
		send('{sfcp_pkg::OP_READ, 8'h00, 8'h00, 8'h00}, 1, 0);
		check(oe_seen, 1'b0, "read while busy");
		wait_idle();
		check(status, 8'h00, "after prog");
	endtask
	task automatic t_erase();
		send('{sfcp_pkg::OP_WREN}, 0, 0);
		send('{sfcp_pkg::OP_SECT, 8'h1F, 8'hAB, 8'hCD}, 0, 0);
		check({last_req.op, last_req.sector}, {sfcp_pkg::SFCP_OP_SECT, 5'h07}, "sector");
		check(sec1, 5'h03, "small sector");
		check(sec16, 5'h1F, "large sector");
		wait_idle();
		send('{sfcp_pkg::OP_WREN}, 0, 0);
		send('{sfcp_pkg::OP_BULK}, 0, 0);
		check(last_req.op, sfcp_pkg::SFCP_OP_BULK, "bulk");
		wait_idle();
		send('{sfcp_pkg::OP_WREN}, 0, 0);
		send('{sfcp_pkg::OP_WRSR, 8'hFC}, 0, 0);
		check({last_req.op, last_req.data}, {sfcp_pkg::SFCP_OP_WRSR, 8'hFC}, "status write");
		wait_idle();
		check(status, 8'hFC, "status stored");
	endtask
	task automatic t_ids();
		int m;
		m = oe16_cnt;
		send('{sfcp_pkg::OP_RSID, 8'h00, 8'h00, 8'h00}, 2, 0);
		check({rdq[0], rdq[1]}, {SID, SID}, "silicon id");
		check(oe16_cnt - m, 0, "silicon id on large");
		send('{sfcp_pkg::OP_RDID, 8'h00, 8'h00}, 1, 0);
		check(oe_seen, 1'b0, "device id absent");
		check(oe16_cnt > m, 1, "device id on large");
		send('{8'hFF, 8'h12}, 1, 0);
		check(oe_seen, 1'b0, "unknown opcode");
	endtask
	// ====
	// main sequence and watchdog
	initial begin
		repeat (5) @(negedge mclk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		t_reset();
		t_wel();
		t_read();
		t_refuse();
		t_prog();
		t_erase();
		t_ids();
		report_and_stop();
	end
	initial begin
		#400000;
		n_mismatch++;
		report_and_stop();
	end
endmodule

// *** sfcp_core.sv ***
// module: serial flash command port, decode, sequencing and busy timing
// Contract
// - all opcodes, addresses and data move most significant bit first
// - after select falls, sample input from the first rising serial clock
// - each input bit latched on a rising serial clock edge
// - read commands shift data out until host deselects, any bit
// - write-type commands run only if select rises on a byte boundary
// - during write or erase cycle refuse all but status read, cycle continues
// - write enable opcode 06, no further bytes, clock up to 25 MHz
// - write disable opcode 04, no further bytes
// - status read opcode 05, status bytes repeat until deselect
// - memory read opcode 03, three address bytes, data streams forever
// - silicon id opcode AB, three dummy bytes, small variants only
// - status write opcode 01, exactly one data byte
// - page program opcode 02, three address bytes, 1 to 256 data
// - bulk erase opcode C7 alone
// - sector erase opcode D8 with three address bytes
// - device id opcode 9F, two dummy bytes, largest variant only
// - 4-Mbit: eight 64 KB sectors, top 70000 to 7FFFF
// - 1-Mbit: four 32 KB sectors, top 18000 to 1FFFF
// - 16-Mbit: thirty-two 64 KB sectors, top 1F0000 to 1FFFFF
// - write enable sets latch bit 1; needed before program, status write, erase
// - latch clears on reset, write disable and operation completion
// - program over 256 bytes keeps only the final 256
// - busy status bit is 1 during write or erase
`timescale 1ns/1ps
module sfcp_core #(
	parameter logic [1:0] VARIANT = sfcp_pkg::VAR_4MBIT,
	parameter int OP_CYCLES = sfcp_pkg::OP_CYCLES,
	parameter logic [7:0] SILICON_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'hA5 // arbitrary value
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic serial_clock_in_i,
	input wire logic serial_cmd_in_i,
	input wire logic chip_select_n_i,
	input wire logic [7:0] mem_rdata_i,
	output logic data_out_o,
	output logic data_oe_n_o,
	output logic [23:0] mem_raddr_o,
	output sfcp_pkg::sfcp_page_type page_o,
	output sfcp_pkg::sfcp_req_type req_o,
	output logic req_valid_o,
	output logic [7:0] status_o
);

	typedef enum logic [2:0] {
		ST_OPCODE = 3'h0,
		ST_ADDR = 3'h1,
		ST_DUMMY = 3'h3,
		ST_DATA = 3'h2,
		ST_READ = 3'h6,
		ST_IGNORE = 3'h7
	} sfcp_state_type;

	// =====================================================
	// pin synchronisation and edge detection
	logic [2:0] pins_sync;
	logic sck_prev_reg;
	logic sck;
	logic sdi;
	logic cs_n;
	logic sck_rise;
	logic sck_fall;
	logic cs_prev_reg;
	logic cs_rise;
	logic cs_fall;

	sfcp_sync #(
		.WIDTH(3)
	) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.async_i({serial_clock_in_i, serial_cmd_in_i, chip_select_n_i}),
		.sync_o(pins_sync)
	);

	assign sck = pins_sync[2];
	assign sdi = pins_sync[1];
	assign cs_n = pins_sync[0];
	assign sck_rise = sck & ~sck_prev_reg & ~cs_n;
	assign sck_fall = ~sck & sck_prev_reg & ~cs_n;
	assign cs_rise = cs_n & ~cs_prev_reg;
	assign cs_fall = ~cs_n & cs_prev_reg;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sck_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
		end else begin
			sck_prev_reg <= sck;
			cs_prev_reg <= cs_n;
		end
	end

	// =====================================================
	// sector decode per variant
	function automatic logic [4:0] sector_of(input logic [23:0] a);
		unique case (VARIANT)
			sfcp_pkg::VAR_1MBIT: sector_of = 5'(a[16:sfcp_pkg::SECT_SHIFT_32K]);
			sfcp_pkg::VAR_4MBIT: sector_of = 5'(a[18:sfcp_pkg::SECT_SHIFT_64K]);
			default: sector_of = a[20:sfcp_pkg::SECT_SHIFT_64K];
		endcase
	endfunction

	function automatic logic [23:0] addr_mask(input logic [23:0] a);
		unique case (VARIANT)
			sfcp_pkg::VAR_1MBIT: addr_mask = a & sfcp_pkg::TOP_1MBIT;
			sfcp_pkg::VAR_4MBIT: addr_mask = a & sfcp_pkg::TOP_4MBIT;
			default: addr_mask = a & sfcp_pkg::TOP_16MBIT;
		endcase
	endfunction

	// =====================================================
	// input shifter
	sfcp_state_type state_reg;
	logic [7:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] opcode_reg;
	logic [1:0] byte_cnt_reg;
	logic [23:0] addr_reg;
	logic [7:0] wrsr_data_reg;
	logic [8:0] prog_cnt_reg;
	logic [7:0] prog_idx_reg;
	logic [7:0] out_reg;
	logic [7:0] status_reg;
	logic [$clog2(OP_CYCLES+1)-1:0] busy_cnt_reg;
	sfcp_pkg::sfcp_op_type pend_op;
	logic [7:0] byte_in;
	logic byte_done;
	logic busy;

	assign busy = status_reg[sfcp_pkg::STAT_BUSY_BIT];
	assign byte_in = {shift_reg[6:0], sdi};
	assign byte_done = sck_rise & (bit_cnt_reg == 3'h7);

	always_ff @(posedge mclk_i) begin
		if (rst_i || cs_fall) begin
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
		end else if (sck_rise) begin
			shift_reg <= byte_in;
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		end
	end

	// =====================================================
	// command sequencer
	always_ff @(posedge mclk_i) begin
		if (rst_i || cs_fall || cs_rise) begin
			state_reg <= ST_OPCODE;
			opcode_reg <= 8'h00;
			byte_cnt_reg <= 2'h0;
		end else if (byte_done) begin
			unique case (state_reg)
				ST_OPCODE: begin
					opcode_reg <= byte_in;
					byte_cnt_reg <= 2'h0;
					if (busy && byte_in != sfcp_pkg::OP_RDSR) begin
						state_reg <= ST_IGNORE;
					end else begin
						unique case (byte_in)
							sfcp_pkg::OP_READ, sfcp_pkg::OP_PROG, sfcp_pkg::OP_SECT: state_reg <= ST_ADDR;
							sfcp_pkg::OP_RDSR: state_reg <= ST_READ;
							sfcp_pkg::OP_RSID: state_reg <= (VARIANT != sfcp_pkg::VAR_16MBIT) ? ST_DUMMY : ST_IGNORE;
							sfcp_pkg::OP_RDID: state_reg <= (VARIANT == sfcp_pkg::VAR_16MBIT) ? ST_DUMMY : ST_IGNORE;
							sfcp_pkg::OP_WRSR: state_reg <= ST_DATA;
							sfcp_pkg::OP_WREN, sfcp_pkg::OP_WRDI, sfcp_pkg::OP_BULK: state_reg <= ST_IGNORE;
							default: state_reg <= ST_IGNORE;
						endcase
					end
				end
				ST_ADDR: begin
					byte_cnt_reg <= byte_cnt_reg + 2'h1;
					if (byte_cnt_reg == 2'(sfcp_pkg::ADDR_BYTES - 1)) begin
						state_reg <= (opcode_reg == sfcp_pkg::OP_READ) ? ST_READ :
							(opcode_reg == sfcp_pkg::OP_PROG) ? ST_DATA : ST_IGNORE;
					end
				end
				ST_DUMMY: begin
					byte_cnt_reg <= byte_cnt_reg + 2'h1;
					if ((opcode_reg == sfcp_pkg::OP_RSID && byte_cnt_reg == 2'(sfcp_pkg::SID_DUMMY_BYTES - 1)) ||
						(opcode_reg == sfcp_pkg::OP_RDID && byte_cnt_reg == 2'(sfcp_pkg::DID_DUMMY_BYTES - 1))) begin
						state_reg <= ST_READ;
					end
				end
				ST_DATA: begin
					if (opcode_reg == sfcp_pkg::OP_WRSR) begin
						state_reg <= ST_IGNORE;
					end
				end
				ST_READ, ST_IGNORE: state_reg <= state_reg;
				default: state_reg <= ST_IGNORE;
			endcase
		end
	end

	// =====================================================
	// address and write data capture
	always_ff @(posedge mclk_i) begin
		if (rst_i || cs_fall) begin
			addr_reg <= 24'h000000;
			wrsr_data_reg <= 8'h00;
			prog_cnt_reg <= 9'h000;
			prog_idx_reg <= 8'h00;
		end else if (byte_done && state_reg == ST_ADDR) begin
			addr_reg <= {addr_reg[15:0], byte_in};
		end else if (byte_done && state_reg == ST_DATA) begin
			wrsr_data_reg <= byte_in;
			// page buffer wraps, so only the final 256 bytes survive
			prog_idx_reg <= prog_idx_reg + 8'h01;
			if (prog_cnt_reg != 9'(sfcp_pkg::PAGE_BYTES)) begin
				prog_cnt_reg <= prog_cnt_reg + 9'h001;
			end
		end else if (byte_done && state_reg == ST_READ && opcode_reg == sfcp_pkg::OP_READ) begin
			addr_reg <= addr_mask(addr_reg + 24'h000001);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			page_o <= '0;
		end else begin
			page_o.wr <= byte_done && state_reg == ST_DATA && opcode_reg == sfcp_pkg::OP_PROG;
			page_o.idx <= addr_reg[7:0] + prog_idx_reg;
			page_o.data <= byte_in;
		end
	end

	// =====================================================
	// read data output, shifted on falling serial clock
	logic [7:0] read_byte;

	always_comb begin
		unique case (opcode_reg)
			sfcp_pkg::OP_RDSR: read_byte = status_reg;
			sfcp_pkg::OP_RSID: read_byte = SILICON_ID;
			sfcp_pkg::OP_RDID: read_byte = DEVICE_ID;
			default: read_byte = mem_rdata_i;
		endcase
	end

	assign mem_raddr_o = addr_reg;

	always_ff @(posedge mclk_i) begin
		if (rst_i || cs_n) begin
			out_reg <= 8'h00;
			data_out_o <= 1'b0;
			data_oe_n_o <= 1'b1;
		end else if (state_reg == ST_READ && sck_fall) begin
			data_oe_n_o <= 1'b0;
			if (bit_cnt_reg == 3'h0) begin
				data_out_o <= read_byte[7];
				out_reg <= {read_byte[6:0], 1'b0};
			end else begin
				data_out_o <= out_reg[7];
				out_reg <= {out_reg[6:0], 1'b0};
			end
		end
	end

	// =====================================================
	// commit on deselect and busy timer
	always_comb begin
		pend_op = sfcp_pkg::SFCP_OP_NONE;
		if (cs_rise && bit_cnt_reg == 3'h0 && status_reg[sfcp_pkg::STAT_WEL_BIT] && !busy) begin
			if (opcode_reg == sfcp_pkg::OP_BULK && state_reg == ST_IGNORE) begin
				pend_op = sfcp_pkg::SFCP_OP_BULK;
			end else if (opcode_reg == sfcp_pkg::OP_SECT && state_reg == ST_IGNORE) begin
				pend_op = sfcp_pkg::SFCP_OP_SECT;
			end else if (opcode_reg == sfcp_pkg::OP_WRSR && state_reg == ST_IGNORE) begin
				pend_op = sfcp_pkg::SFCP_OP_WRSR;
			end else if (opcode_reg == sfcp_pkg::OP_PROG && state_reg == ST_DATA && prog_cnt_reg != 9'h000) begin
				pend_op = sfcp_pkg::SFCP_OP_PROG;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			req_o <= '0;
			req_valid_o <= 1'b0;
		end else begin
			req_valid_o <= pend_op != sfcp_pkg::SFCP_OP_NONE;
			req_o.op <= pend_op;
			req_o.addr <= addr_mask(addr_reg);
			req_o.sector <= sector_of(addr_reg);
			req_o.data <= wrsr_data_reg;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			status_reg <= sfcp_pkg::STAT_RESET;
			busy_cnt_reg <= '0;
		end else if (pend_op != sfcp_pkg::SFCP_OP_NONE) begin
			status_reg[sfcp_pkg::STAT_BUSY_BIT] <= 1'b1;
			busy_cnt_reg <= ($clog2(OP_CYCLES+1))'(OP_CYCLES);
			if (pend_op == sfcp_pkg::SFCP_OP_WRSR) begin
				status_reg[7:2] <= wrsr_data_reg[7:2];
			end
		end else if (busy) begin
			busy_cnt_reg <= busy_cnt_reg - 1'b1;
			if (busy_cnt_reg == 1) begin
				status_reg[sfcp_pkg::STAT_BUSY_BIT] <= 1'b0;
				status_reg[sfcp_pkg::STAT_WEL_BIT] <= 1'b0;
			end
		end else if (cs_rise && bit_cnt_reg == 3'h0 && state_reg == ST_IGNORE) begin
			if (opcode_reg == sfcp_pkg::OP_WREN) begin
				status_reg[sfcp_pkg::STAT_WEL_BIT] <= 1'b1;
			end else if (opcode_reg == sfcp_pkg::OP_WRDI) begin
				status_reg[sfcp_pkg::STAT_WEL_BIT] <= 1'b0;
			end
		end
	end

	assign status_o = status_reg;

endmodule

// *** sfcp_core_checker.sv ***
// checker: port-level assertions for the flash command port
`timescale 1ns/1ps
module sfcp_core_checker #(
	parameter logic [1:0] VARIANT = sfcp_pkg::VAR_4MBIT,
	parameter int OP_CYCLES = sfcp_pkg::OP_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic serial_clock_in_i,
	input wire logic serial_cmd_in_i,
	input wire logic chip_select_n_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic data_out_o,
	input wire logic data_oe_n_o,
	input wire logic [23:0] mem_raddr_o,
	input wire sfcp_pkg::sfcp_page_type page_o,
	input wire sfcp_pkg::sfcp_req_type req_o,
	input wire logic req_valid_o,
	input wire logic [7:0] status_o
);
	// ====
	// helpers
	int busy_cnt;
	logic [4:0] sect_exp;
	always_ff @(posedge mclk_i) begin
		if (rst_i || !status_o[0]) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end
	always_comb begin
		if (VARIANT == sfcp_pkg::VAR_1MBIT) begin
			sect_exp = {3'h0, req_o.addr[16:15]};
		end else if (VARIANT == sfcp_pkg::VAR_4MBIT) begin
			sect_exp = {2'h0, req_o.addr[18:16]};
		end else begin
			sect_exp = req_o.addr[20:16];
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// ====
	// properties
	property p_oe_idle; chip_select_n_i [*5] |-> data_oe_n_o; endproperty
	property p_req_pulse; req_valid_o |=> !req_valid_o; endproperty
	property p_req_desel; req_valid_o |-> $past(chip_select_n_i, 2); endproperty
	property p_busy_set; req_valid_o |-> status_o[0]; endproperty
	// one cycle of slack either way on the busy span
	property p_busy_len;
		$fell(status_o[0]) |-> busy_cnt >= OP_CYCLES - 1 && busy_cnt <= OP_CYCLES + 1;
	endproperty
	property p_wel_clear; $fell(status_o[0]) |-> !status_o[1]; endproperty
	property p_need_wel; req_valid_o |-> $past(status_o[1]); endproperty
	property p_not_busy; req_valid_o |-> !$past(status_o[0]); endproperty
	property p_sector; req_valid_o && req_o.op == sfcp_pkg::SFCP_OP_SECT |-> req_o.sector == sect_exp; endproperty
	property p_wel_rise; $rose(status_o[1]) |-> $past(chip_select_n_i, 2); endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("output enabled while deselected");
	a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");
	a_req_desel: assert property (p_req_desel) else $error("request before deselect");
	a_busy_set: assert property (p_busy_set) else $error("busy not set with request");
	a_busy_len: assert property (p_busy_len) else $error("busy span wrong");
	a_wel_clear: assert property (p_wel_clear) else $error("latch kept after operation");
	a_need_wel: assert property (p_need_wel) else $error("request without latch");
	a_not_busy: assert property (p_not_busy) else $error("request while busy");
	a_sector: assert property (p_sector) else $error("sector decode wrong");
	a_wel_rise: assert property (p_wel_rise) else $error("latch set before deselect");
	c_prog: cover property (req_valid_o && req_o.op == sfcp_pkg::SFCP_OP_PROG);
	c_sect: cover property (req_valid_o && req_o.op == sfcp_pkg::SFCP_OP_SECT);
	c_read: cover property (!data_oe_n_o);
endmodule

bind sfcp_core sfcp_core_checker #(.VARIANT(VARIANT), .OP_CYCLES(OP_CYCLES)) chk_u (
	.mclk_i(mclk_i), .rst_i(rst_i), .serial_clock_in_i(serial_clock_in_i),
	.serial_cmd_in_i(serial_cmd_in_i), .chip_select_n_i(chip_select_n_i), .mem_rdata_i(mem_rdata_i),
	.data_out_o(data_out_o), .data_oe_n_o(data_oe_n_o), .mem_raddr_o(mem_raddr_o), .page_o(page_o),
	.req_o(req_o), .req_valid_o(req_valid_o), .status_o(status_o));

// *** sfcp_host.sv ***
// partner: host driving the serial link, plus a read-only array image
`timescale 1ns/1ps
module sfcp_host (
	input wire logic mclk_i,
	input wire logic data_i,
	input wire logic oe_n_i,
	input wire logic [23:0] raddr_i,
	output logic sck_o,
	output logic sdi_o,
	output logic cs_n_o,
	output logic [7:0] rdata_o,
	output logic oe_seen_o
);
	assign rdata_o = raddr_i[7:0] ^ raddr_i[15:8] ^ raddr_i[23:16] ^ 8'h3C;
	initial begin
		sck_o = 1'b0;
		sdi_o = 1'b0;
		cs_n_o = 1'b1;
		oe_seen_o = 1'b0;
	end
	always @(posedge mclk_i) begin
		if (!oe_n_i) oe_seen_o <= 1'b1;
	end
	task automatic open_frame();
		@(negedge mclk_i);
		cs_n_o = 1'b0;
		oe_seen_o = 1'b0;
		repeat (4) @(negedge mclk_i);
	endtask
	// 16 mclk per bit: 80 ns link period, below every clock limit
	task automatic shift(input logic [7:0] b, input int n, output logic [7:0] r);
		r = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			sdi_o = b[i];
			repeat (8) @(negedge mclk_i);
			sck_o = 1'b1;
			// a disabled output floats: read the inverse so a stale bit cannot pass
			r[i] = oe_n_i ? ~data_i : data_i;
			repeat (8) @(negedge mclk_i);
			sck_o = 1'b0;
		end
	endtask
	// released data line shows the inverse, not a stale value
	task automatic close_frame();
		repeat (4) @(negedge mclk_i);
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
		repeat (8) @(negedge mclk_i);
	endtask
endmodule

// *** sfcp_pkg.sv ***
// package: opcodes, sizes, status bits and link types of the flash command port
package sfcp_pkg;

	// =====================================================
	// opcodes
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_RSID = 8'hAB;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_BULK = 8'hC7;
	localparam logic [7:0] OP_SECT = 8'hD8;
	localparam logic [7:0] OP_RDID = 8'h9F;

	// =====================================================
	// byte counts and sizes
	localparam int ADDR_BYTES = 3;
	localparam int SID_DUMMY_BYTES = 3;
	localparam int DID_DUMMY_BYTES = 2;
	localparam int PAGE_BYTES = 256;
	localparam int BYTE_BITS = 8;

	// =====================================================
	// status register fields and reset value
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_WEL_BIT = 1;
	localparam logic [7:0] STAT_RESET = 8'h00;

	// =====================================================
	// density variants and sector geometry
	localparam logic [1:0] VAR_1MBIT = 2'h0;
	localparam logic [1:0] VAR_4MBIT = 2'h1;
	localparam logic [1:0] VAR_16MBIT = 2'h2;
	localparam int SECT_SHIFT_32K = 15;
	localparam int SECT_SHIFT_64K = 16;
	localparam logic [23:0] TOP_1MBIT = 24'h01FFFF;
	localparam logic [23:0] TOP_4MBIT = 24'h07FFFF;
	localparam logic [23:0] TOP_16MBIT = 24'h1FFFFF;

	// =====================================================
	// timing
	localparam int MCLK_MHZ = 200;
	localparam int OP_TIME_US = 10;
	localparam int OP_CYCLES = OP_TIME_US * MCLK_MHZ;

	// =====================================================
	// command execution request to the array engine
	typedef enum logic [2:0] {
		SFCP_OP_NONE = 3'h0,
		SFCP_OP_PROG = 3'h1,
		SFCP_OP_WRSR = 3'h3,
		SFCP_OP_SECT = 3'h2,
		SFCP_OP_BULK = 3'h6
	} sfcp_op_type;

	typedef struct packed {
		sfcp_op_type op;
		logic [23:0] addr;
		logic [4:0] sector;
		logic [7:0] data;
	} sfcp_req_type;

	// page write port toward the array
	typedef struct packed {
		logic wr;
		logic [7:0] idx;
		logic [7:0] data;
	} sfcp_page_type;

endpackage

// *** sfcp_sync.sv ***
// module: two-flop synchroniser for the serial link pins
`timescale 1ns/1ps
module sfcp_sync #(
	parameter int WIDTH = 3
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			meta_reg <= '1;
			sync_o <= '1;
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end

endmodule
